// [pin_world.sv]
// Purpose: Far side of one port: resolves pin levels from driver and outside world
// Assumes: Outside logic drives every pin that the device leaves as input
// Notes: No pull-ups; a released pin shows what the outside drives
`timescale 1ns/10ps
module pin_world
(
  input wire [7:0] i_out,
  input wire [7:0] i_oe,
  input wire [7:0] i_ext,
  output wire [7:0] o_pin
);
  // Device bits win where enabled, outside level elsewhere
  assign o_pin = (i_out & i_oe) | (i_ext & ~i_oe);
endmodule // pin_world

// [port_slice.v]
// Purpose: One bidirectional eight-bit port: latch drive, direction, pin read
// Assumes: Pin input comes from outside the clock domain
// Notes: Read value passes a two-stage synchroniser
`timescale 1ns/10ps
`include "sfr_core_map.vh"

module port_slice
(
  input wire i_clock,
  input wire i_rst,
  input wire i_latch_we,
  input wire i_dir_we,
  input wire [7:0] i_wdata,
  input wire [7:0] i_pin_in,
  output wire [7:0] o_pin_out,
  output wire [7:0] o_pin_oe,
  output wire [7:0] o_latch,
  output wire [7:0] o_direction,
  output wire [7:0] o_pin_state
);

  reg [7:0] latch_reg; // Output latch
  reg [7:0] dir_reg; // Direction, 1 means output
  reg [7:0] sync1_reg; // First synchroniser stage
  reg [7:0] sync2_reg; // Second synchroniser stage

  // Latch, direction and pin synchroniser
  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      latch_reg <= `RST_PORT_LATCH;
      dir_reg <= `RST_PORT_DIRECTION;
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end
    else
    begin
      if (i_latch_we)
        latch_reg <= i_wdata;
      if (i_dir_we)
        dir_reg <= i_wdata;
      sync1_reg <= i_pin_in;
      sync2_reg <= sync1_reg; // RL12
    end
  end

  assign o_pin_out = latch_reg; // RL10
  assign o_pin_oe = dir_reg; // RL11
  assign o_latch = latch_reg;
  assign o_direction = dir_reg;
  assign o_pin_state = sync2_reg; // RL12

endmodule // port_slice

// [sfr_core_bank.v]
// Purpose: Core special registers, three ports and stretched external moves
// Assumes: Instruction engine drives the register port and control pulses
// Notes: Register reads are registered, one cycle after the read strobe
`timescale 1ns/10ps
`include "sfr_core_map.vh"

// Contract
// [RL1] Status word flags at bits 7,6,5,2,1
// [RL2] Bits 4:3 select working register bank
// [RL3] Bit 0 shows accumulator odd parity
// [RL4] Stack pointer resets to 0x07
// [RL5] Stack pointer increments before each push/call
// [RL6] Two 16-bit pointers at 0x82..0x85
// [RL7] Pointer bytes separately writable; supply move addresses
// [RL8] Program counter 16 bits, resets zero
// [RL9] Counter advances on opcode and operand fetch
// [RL10] Port latches drive the matching pins
// [RL11] Direction bit one makes pin output
// [RL12] Port reads return actual pin state
// [RL13] Stretch field bits 2:0 sets wait cycles
// [RL14] Stretch field resets to one
// [RL15] Read strobes last stretch plus one
// [RL16] Write: address s+2, strobe s (min 1)
module sfr_core_bank
(
  input wire i_clock,
  input wire i_rst,
  input wire [7:0] i_sfr_addr,
  input wire [7:0] i_sfr_wdata,
  input wire i_sfr_we,
  input wire i_sfr_re,
  output reg [7:0] o_sfr_rdata,
  input wire [7:0] i_accumulator,
  input wire i_flags_we,
  input wire [7:0] i_flags_data,
  input wire i_stack_push,
  input wire i_stack_pop,
  output wire [7:0] o_stack_addr,
  input wire i_opcode_fetch,
  input wire i_operand_fetch,
  input wire i_pc_load,
  input wire [15:0] i_pc_target,
  output wire [15:0] o_program_counter,
  input wire i_pointer_select,
  input wire i_pointer_inc,
  output wire [15:0] o_data_pointer,
  output wire [4:0] o_bank_base,
  input wire i_xmem_start,
  input wire i_xmem_write,
  output wire o_xmem_busy,
  output wire [15:0] o_xmem_addr,
  output wire o_addr_valid,
  output wire o_read_strobe,
  output wire o_write_strobe,
  input wire [7:0] i_port0_in,
  output wire [7:0] o_port0_out,
  output wire [7:0] o_port0_oe,
  input wire [7:0] i_port1_in,
  output wire [7:0] o_port1_out,
  output wire [7:0] o_port1_oe,
  input wire [7:0] i_port2_in,
  output wire [7:0] o_port2_out,
  output wire [7:0] o_port2_oe
);

  // Architectural registers; each is written by one process only
  reg [7:0] status_reg; // Status word bits 7:1 (bit 0 derived)
  reg [7:0] stack_pointer_reg; // Stack pointer
  reg [7:0] ptr0_low_reg; // Pointer zero low byte
  reg [7:0] ptr0_high_reg; // Pointer zero high byte
  reg [7:0] ptr1_low_reg; // Pointer one low byte
  reg [7:0] ptr1_high_reg; // Pointer one high byte
  reg [15:0] program_counter_reg; // Program counter
  reg [2:0] stretch_reg; // Memory stretch field
  reg [15:0] xmem_addr_reg; // Address held for the move
  reg [7:0] rdata_next; // Read mux result
  // Derived values and submodule outputs
  wire parity_bit; // Accumulator parity
  wire [7:0] status_word; // Status word as seen
  wire [15:0] ptr0_word; // Pointer zero
  wire [15:0] ptr1_word; // Pointer one
  wire [15:0] ptr_inc; // Selected pointer plus one
  wire [7:0] p0_dir, p1_dir, p2_dir; // Port directions
  wire [7:0] p0_pin, p1_pin, p2_pin; // Synchronised pins
  wire wr; // Register write strobe

  // Combinational views; parity is never stored, so it tracks the
  // accumulator in the same cycle that the engine changes it
  assign wr = i_sfr_we;
  assign parity_bit = ^i_accumulator; // RL3
  assign status_word = {status_reg[7:1], parity_bit}; // RL1
  assign ptr0_word = {ptr0_high_reg, ptr0_low_reg}; // RL6
  assign ptr1_word = {ptr1_high_reg, ptr1_low_reg}; // RL6
  assign o_data_pointer = i_pointer_select ? ptr1_word : ptr0_word; // RL7
  assign ptr_inc = o_data_pointer + 16'h0001;
  // Bank base is the first byte of the selected eight-byte bank
  assign o_bank_base = {status_reg[`SW_BANK_HIGH], status_reg[`SW_BANK_LOW], 3'b000}; // RL2
  assign o_stack_addr = stack_pointer_reg;
  assign o_program_counter = program_counter_reg;
  assign o_xmem_addr = xmem_addr_reg;

  // Status word: flag updates from the engine, software write wins
  // Bit 0 is stored as zero; reads substitute the live parity
  always @(posedge i_clock)
  begin
    if (i_rst)
      status_reg <= `RST_STATUS_WORD;
    else if (wr && i_sfr_addr == `ADDR_STATUS_WORD)
      status_reg <= {i_sfr_wdata[7:1], 1'b0}; // RL1
    else if (i_flags_we)
      status_reg <= {i_flags_data[7:1], 1'b0}; // RL1
  end

  // Stack pointer: pre-increment on push, decrement on pop
  // A push and a pop in one cycle resolve as a push
  always @(posedge i_clock)
  begin
    if (i_rst)
      stack_pointer_reg <= `RST_STACK_POINTER; // RL4
    else if (wr && i_sfr_addr == `ADDR_STACK_POINTER)
      stack_pointer_reg <= i_sfr_wdata;
    else if (i_stack_push)
      stack_pointer_reg <= stack_pointer_reg + 8'h01; // RL5
    else if (i_stack_pop)
      stack_pointer_reg <= stack_pointer_reg - 8'h01;
  end

  // Data pointers: byte writes, or increment of the selected one
  // A byte write in the same cycle as an increment keeps the written byte
  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      ptr0_low_reg <= `RST_POINTER;
      ptr0_high_reg <= `RST_POINTER;
      ptr1_low_reg <= `RST_POINTER;
      ptr1_high_reg <= `RST_POINTER;
    end
    else if (wr)
    begin
      if (i_sfr_addr == `ADDR_POINTER0_LOW)
        ptr0_low_reg <= i_sfr_wdata; // RL7
      else if (i_sfr_addr == `ADDR_POINTER0_HIGH)
        ptr0_high_reg <= i_sfr_wdata; // RL7
      else if (i_sfr_addr == `ADDR_POINTER1_LOW)
        ptr1_low_reg <= i_sfr_wdata; // RL7
      else if (i_sfr_addr == `ADDR_POINTER1_HIGH)
        ptr1_high_reg <= i_sfr_wdata; // RL7
    end
    else if (i_pointer_inc)
    begin
      // Carry from the low byte ripples into the high byte
      if (i_pointer_select)
      begin
        ptr1_low_reg <= ptr_inc[7:0];
        ptr1_high_reg <= ptr_inc[15:8];
      end
      else
      begin
        ptr0_low_reg <= ptr_inc[7:0];
        ptr0_high_reg <= ptr_inc[15:8];
      end
    end
  end

  // Program counter: load for jumps, else advance per fetch
  // A load in the same cycle as a fetch takes the target, not target plus one
  always @(posedge i_clock)
  begin
    if (i_rst)
      program_counter_reg <= `RST_PROGRAM_COUNTER; // RL8
    else if (i_pc_load)
      program_counter_reg <= i_pc_target;
    else if (i_opcode_fetch || i_operand_fetch)
      program_counter_reg <= program_counter_reg + 16'h0001; // RL9
  end

  // Stretch field and captured move address
  // The timer reads the field only at a start, so a change made during a
  // move affects the next move, never the one in flight
  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      stretch_reg <= `RST_STRETCH; // RL14
      xmem_addr_reg <= 16'h0000;
    end
    else
    begin
      if (wr && i_sfr_addr == `ADDR_STRETCH_CONTROL)
        stretch_reg <= i_sfr_wdata[`STRETCH_MSB:0]; // RL13
      if (i_xmem_start && !o_xmem_busy)
        xmem_addr_reg <= o_data_pointer; // RL7
    end
  end

  // External move strobe timer
  // A start while busy is ignored here and by the address capture above
  xmem_strobe u_xmem
  (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_start(i_xmem_start),
    .i_write(i_xmem_write),
    .i_stretch(stretch_reg), // RL13
    .o_busy(o_xmem_busy),
    .o_addr_valid(o_addr_valid),
    .o_read_strobe(o_read_strobe),
    .o_write_strobe(o_write_strobe)
  );

  // Latch copies are not read back: port addresses return the pins
  // Port 0
  port_slice u_port0
  (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_latch_we(wr && i_sfr_addr == `ADDR_PORT0_LATCH),
    .i_dir_we(wr && i_sfr_addr == `ADDR_PORT0_DIRECTION), // RL11
    .i_wdata(i_sfr_wdata),
    .i_pin_in(i_port0_in),
    .o_pin_out(o_port0_out),
    .o_pin_oe(o_port0_oe),
    .o_latch(),
    .o_direction(p0_dir),
    .o_pin_state(p0_pin)
  );

  // Port 1 and port 2 differ from port 0 only in their addresses
  // Port 1
  port_slice u_port1
  (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_latch_we(wr && i_sfr_addr == `ADDR_PORT1_LATCH),
    .i_dir_we(wr && i_sfr_addr == `ADDR_PORT1_DIRECTION), // RL11
    .i_wdata(i_sfr_wdata),
    .i_pin_in(i_port1_in),
    .o_pin_out(o_port1_out),
    .o_pin_oe(o_port1_oe),
    .o_latch(),
    .o_direction(p1_dir),
    .o_pin_state(p1_pin)
  );

  // Port 2
  port_slice u_port2
  (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_latch_we(wr && i_sfr_addr == `ADDR_PORT2_LATCH),
    .i_dir_we(wr && i_sfr_addr == `ADDR_PORT2_DIRECTION), // RL11
    .i_wdata(i_sfr_wdata),
    .i_pin_in(i_port2_in),
    .o_pin_out(o_port2_out),
    .o_pin_oe(o_port2_oe),
    .o_latch(),
    .o_direction(p2_dir),
    .o_pin_state(p2_pin)
  );

  // Read decode; unmapped addresses read zero
  // Pin values reach this mux two edges after they change at the pins
  always @*
  begin
    rdata_next = 8'h00;
    if (i_sfr_addr == `ADDR_PORT0_LATCH)
      rdata_next = p0_pin; // RL12
    else if (i_sfr_addr == `ADDR_PORT1_LATCH)
      rdata_next = p1_pin; // RL12
    else if (i_sfr_addr == `ADDR_PORT2_LATCH)
      rdata_next = p2_pin; // RL12
    else if (i_sfr_addr == `ADDR_PORT0_DIRECTION)
      rdata_next = p0_dir;
    else if (i_sfr_addr == `ADDR_PORT1_DIRECTION)
      rdata_next = p1_dir;
    else if (i_sfr_addr == `ADDR_PORT2_DIRECTION)
      rdata_next = p2_dir;
    else if (i_sfr_addr == `ADDR_STACK_POINTER)
      rdata_next = stack_pointer_reg;
    else if (i_sfr_addr == `ADDR_POINTER0_LOW)
      rdata_next = ptr0_low_reg;
    else if (i_sfr_addr == `ADDR_POINTER0_HIGH)
      rdata_next = ptr0_high_reg;
    else if (i_sfr_addr == `ADDR_POINTER1_LOW)
      rdata_next = ptr1_low_reg;
    else if (i_sfr_addr == `ADDR_POINTER1_HIGH)
      rdata_next = ptr1_high_reg;
    else if (i_sfr_addr == `ADDR_STRETCH_CONTROL)
      rdata_next = {5'b00000, stretch_reg};
    else if (i_sfr_addr == `ADDR_STATUS_WORD)
      rdata_next = status_word; // RL3
  end

  // Registered read data
  // Data stands until the next read strobe, so a late look still sees it
  always @(posedge i_clock)
  begin
    if (i_rst)
      o_sfr_rdata <= 8'h00;
    else if (i_sfr_re)
      o_sfr_rdata <= rdata_next;
  end

endmodule // sfr_core_bank

// [sfr_core_bank_chk.sv]
// Purpose: Port assertions for the core register bank
// Assumes: One clock, synchronous active-high reset
// Notes: Shadows the stretch field from register writes
`timescale 1ns/10ps
module sfr_core_bank_chk
(
  input wire i_clock,
  input wire i_rst,
  input wire [7:0] i_sfr_addr,
  input wire [7:0] i_sfr_wdata,
  input wire i_sfr_we,
  input wire i_sfr_re,
  input wire [7:0] o_sfr_rdata,
  input wire [7:0] i_accumulator,
  input wire i_stack_push,
  input wire [7:0] o_stack_addr,
  input wire i_opcode_fetch,
  input wire i_operand_fetch,
  input wire i_pc_load,
  input wire [15:0] o_program_counter,
  input wire [4:0] o_bank_base,
  input wire i_xmem_start,
  input wire i_xmem_write,
  input wire o_xmem_busy,
  input wire o_addr_valid,
  input wire o_read_strobe,
  input wire o_write_strobe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  reg [2:0] st_reg; // Stretch field shadow
  reg [2:0] cap_reg; // Stretch of the move in flight
  reg wr_reg; // Move in flight is a write
  reg [3:0] av_reg; // Run lengths of each strobe
  reg [3:0] rd_reg;
  reg [3:0] ws_reg;
  // Shadow and strobe run counters
  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      st_reg <= 3'h1;
      cap_reg <= 3'h1;
      wr_reg <= 1'b0;
      av_reg <= 4'h0;
      rd_reg <= 4'h0;
      ws_reg <= 4'h0;
    end
    else
    begin
      if (i_sfr_we && i_sfr_addr == 8'h8e)
        st_reg <= i_sfr_wdata[2:0];
      if (i_xmem_start && !o_xmem_busy)
      begin
        cap_reg <= st_reg;
        wr_reg <= i_xmem_write;
      end
      av_reg <= o_addr_valid ? av_reg + 4'h1 : 4'h0;
      rd_reg <= o_read_strobe ? rd_reg + 4'h1 : 4'h0;
      ws_reg <= o_write_strobe ? ws_reg + 4'h1 : 4'h0;
    end
  end
  chk_reset_values: assert property ($past(i_rst) |-> o_stack_addr == 8'h07
    && o_program_counter == 16'h0000) else $error("reset values wrong");
  chk_push_pre_inc: assert property (i_stack_push && !i_sfr_we |=>
    o_stack_addr == $past(o_stack_addr) + 8'h01) else $error("push did not increment");
  chk_pc_advance: assert property ((i_opcode_fetch || i_operand_fetch) && !i_pc_load |=>
    o_program_counter == $past(o_program_counter) + 16'h0001) else $error("pc did not advance");
  chk_bank_select: assert property (i_sfr_we && i_sfr_addr == 8'hd0 |=>
    o_bank_base == {$past(i_sfr_wdata[4:3]), 3'b000}) else $error("bank base wrong");
  chk_parity_bit: assert property (i_sfr_re && i_sfr_addr == 8'hd0 |=>
    o_sfr_rdata[0] == ^$past(i_accumulator)) else $error("parity bit wrong");
  chk_move_opens: assert property (i_xmem_start && !o_xmem_busy |=> o_addr_valid)
    else $error("move did not start");
  chk_read_width: assert property ($fell(o_read_strobe) |->
    rd_reg == {1'b0, cap_reg} + 4'h1) else $error("read strobe width wrong");
  chk_write_width: assert property ($fell(o_write_strobe) |->
    ws_reg == ((cap_reg == 3'h0) ? 4'h1 : {1'b0, cap_reg}))
    else $error("write strobe width wrong");
  chk_addr_width: assert property ($fell(o_addr_valid) |->
    av_reg == {1'b0, cap_reg} + (wr_reg ? 4'h2 : 4'h1)) else $error("address strobe width wrong");
  cov_read: cover property ($fell(o_read_strobe));
  cov_write: cover property ($fell(o_write_strobe));
  cov_push: cover property (i_stack_push);
endmodule // sfr_core_bank_chk
bind sfr_core_bank sfr_core_bank_chk sfr_core_bank_chk_inst (.i_clock(i_clock), .i_rst(i_rst),
  .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_we(i_sfr_we), .i_sfr_re(i_sfr_re),
  .o_sfr_rdata(o_sfr_rdata), .i_accumulator(i_accumulator), .i_stack_push(i_stack_push),
  .o_stack_addr(o_stack_addr), .i_opcode_fetch(i_opcode_fetch), .i_operand_fetch(i_operand_fetch),
  .i_pc_load(i_pc_load), .o_program_counter(o_program_counter), .o_bank_base(o_bank_base),
  .i_xmem_start(i_xmem_start), .i_xmem_write(i_xmem_write), .o_xmem_busy(o_xmem_busy),
  .o_addr_valid(o_addr_valid), .o_read_strobe(o_read_strobe), .o_write_strobe(o_write_strobe));

// [sfr_core_map.vh]
// Purpose: Addresses, field positions, reset values and timing counts of the core register bank
// Assumes: Eight-bit special register address space, one processor clock
// Notes: Included by every design file of the bank
`ifndef SFR_CORE_MAP_VH
`define SFR_CORE_MAP_VH

// Register addresses
`define ADDR_PORT0_LATCH 8'h80
`define ADDR_STACK_POINTER 8'h81
`define ADDR_POINTER0_LOW 8'h82
`define ADDR_POINTER0_HIGH 8'h83
`define ADDR_POINTER1_LOW 8'h84
`define ADDR_POINTER1_HIGH 8'h85
`define ADDR_STRETCH_CONTROL 8'h8e
`define ADDR_PORT1_LATCH 8'h90
`define ADDR_PORT1_DIRECTION 8'h91
`define ADDR_PORT2_LATCH 8'ha0
`define ADDR_PORT2_DIRECTION 8'ha1
`define ADDR_PORT0_DIRECTION 8'ha2
`define ADDR_STATUS_WORD 8'hd0

// Status word field positions
`define SW_CARRY 7
`define SW_AUX_CARRY 6
`define SW_USER_ZERO 5
`define SW_BANK_HIGH 4
`define SW_BANK_LOW 3
`define SW_OVERFLOW 2
`define SW_USER_ONE 1
`define SW_PARITY 0

// Reset values
`define RST_STACK_POINTER 8'h07
`define RST_PROGRAM_COUNTER 16'h0000
`define RST_PORT_LATCH 8'hff
`define RST_PORT_DIRECTION 8'h00
`define RST_POINTER 8'h00
`define RST_STATUS_WORD 8'h00
`define RST_STRETCH 3'h1
`define STRETCH_MSB 2

// Strobe width offsets in processor cycles
`define RD_EXTRA 4'h1
`define WR_ADDR_EXTRA 4'h2
`define WR_STROBE_MIN 4'h1

`endif

// [tb_sfr_core_bank.sv]
// Purpose: Self-checking bench for the core register bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Ports see the pin_world partner
`timescale 1ns/10ps
module tb_sfr_core_bank;
  reg i_clock = 1'b0;
  reg i_rst = 1'b1;
  reg [7:0] i_sfr_addr = 8'h00;
  reg [7:0] i_sfr_wdata = 8'h00;
  reg i_sfr_we = 1'b0;
  reg i_sfr_re = 1'b0;
  reg [7:0] i_accumulator = 8'h00;
  reg i_stack_push = 1'b0;
  reg i_stack_pop = 1'b0;
  reg i_opcode_fetch = 1'b0;
  reg i_operand_fetch = 1'b0;
  reg i_pc_load = 1'b0;
  reg [15:0] i_pc_target = 16'h0000;
  reg i_pointer_select = 1'b0;
  reg i_xmem_start = 1'b0;
  reg i_xmem_write = 1'b0;
  reg i_flags_we = 1'b0;
  reg [7:0] i_flags_data = 8'h00;
  reg i_pointer_inc = 1'b0;
  reg [2:0][7:0] ext = '0; // Outside levels on the pins
  wire [2:0][7:0] pout, poe, pin;
  wire [7:0] o_sfr_rdata, o_stack_addr;
  wire [15:0] o_program_counter, o_data_pointer, o_xmem_addr;
  wire [4:0] o_bank_base;
  wire o_xmem_busy, o_addr_valid, o_read_strobe, o_write_strobe;
  int fail_count = 0;
  int samples_checked = 0;
  sfr_core_bank sfr_core_bank_inst (.i_clock(i_clock), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wdata(i_sfr_wdata), .i_sfr_we(i_sfr_we), .i_sfr_re(i_sfr_re),
    .o_sfr_rdata(o_sfr_rdata), .i_accumulator(i_accumulator), .i_flags_we(i_flags_we),
    .i_flags_data(i_flags_data), .i_stack_push(i_stack_push), .i_stack_pop(i_stack_pop),
    .o_stack_addr(o_stack_addr), .i_opcode_fetch(i_opcode_fetch),
    .i_operand_fetch(i_operand_fetch), .i_pc_load(i_pc_load), .i_pc_target(i_pc_target),
    .o_program_counter(o_program_counter), .i_pointer_select(i_pointer_select),
    .i_pointer_inc(i_pointer_inc), .o_data_pointer(o_data_pointer), .o_bank_base(o_bank_base),
    .i_xmem_start(i_xmem_start), .i_xmem_write(i_xmem_write), .o_xmem_busy(o_xmem_busy),
    .o_xmem_addr(o_xmem_addr), .o_addr_valid(o_addr_valid), .o_read_strobe(o_read_strobe),
    .o_write_strobe(o_write_strobe), .i_port0_in(pin[0]), .o_port0_out(pout[0]),
    .o_port0_oe(poe[0]), .i_port1_in(pin[1]), .o_port1_out(pout[1]), .o_port1_oe(poe[1]),
    .i_port2_in(pin[2]), .o_port2_out(pout[2]), .o_port2_oe(poe[2]));
  genvar g;
  // One partner per port
  for (g = 0; g < 3; g = g + 1)
  begin : gp
    pin_world pin_world_inst (.i_out(pout[g]), .i_oe(poe[g]), .i_ext(ext[g]), .o_pin(pin[g]));
  end
  // Clock, 10 ns period
  initial
  begin
    forever #5 i_clock = ~i_clock;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task tick;
  begin
    @(posedge i_clock);
    #1;
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_we = 1'b1;
    tick;
    i_sfr_we = 1'b0;
    tick; // Idle edge keeps back-to-back writes apart
  end
  endtask
  task automatic rd_chk(input string nm, input [7:0] a, input [7:0] exp);
  begin
    i_sfr_addr = a;
    i_sfr_re = 1'b1;
    tick;
    i_sfr_re = 1'b0;
    chk(nm, {8'h00, o_sfr_rdata}, {8'h00, exp});
    tick; // Idle edge keeps back-to-back reads apart
  end
  endtask
  task t_reset;
  begin
    rd_chk("stack", 8'h81, 8'h07);
    chk("pc", o_program_counter, 16'h0000);
    rd_chk("stretch", 8'h8e, 8'h01);
    rd_chk("status", 8'hd0, 8'h00);
    $display("reset test done");
  end
  endtask
  task automatic t_status;
    int b;
  begin
    i_accumulator = 8'h07;
    wr(8'hd0, 8'hfe);
    rd_chk("status", 8'hd0, 8'hff);
    for (b = 0; b < 4; b++)
    begin
      wr(8'hd0, 8'(b << 3));
      chk("bank", {11'h0, o_bank_base}, 16'(b * 8));
    end
    i_accumulator = 8'h03;
    rd_chk("parity", 8'hd0, 8'h18);
    i_flags_data = 8'ha5;
    i_flags_we = 1'b1;
    tick;
    i_flags_we = 1'b0;
    rd_chk("flags", 8'hd0, 8'ha4);
    $display("status test done");
  end
  endtask
  task t_stack_pc;
  begin
    i_stack_push = 1'b1;
    tick;
    chk("push", o_stack_addr, 16'h0008);
    i_stack_pop = 1'b1;
    tick;
    i_stack_push = 1'b0;
    tick;
    i_stack_pop = 1'b0;
    chk("pop", o_stack_addr, 16'h0008);
    i_opcode_fetch = 1'b1;
    tick;
    i_opcode_fetch = 1'b0;
    i_operand_fetch = 1'b1;
    tick;
    i_operand_fetch = 1'b0;
    chk("pc", o_program_counter, 16'h0002);
    i_pc_target = 16'hfffe;
    i_pc_load = 1'b1;
    tick;
    i_pc_load = 1'b0;
    i_opcode_fetch = 1'b1;
    tick;
    i_opcode_fetch = 1'b0;
    chk("pc", o_program_counter, 16'hffff);
    $display("stack and counter test done");
  end
  endtask
  task t_pointers;
  begin
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    wr(8'h84, 8'hcd);
    wr(8'h85, 8'hab);
    chk("pointer0", o_data_pointer, 16'h1234);
    i_pointer_inc = 1'b1;
    tick;
    i_pointer_inc = 1'b0;
    chk("pointer0 step", o_data_pointer, 16'h1235);
    i_pointer_select = 1'b1;
    tick;
    chk("pointer1", o_data_pointer, 16'habcd);
    rd_chk("pointer1 high", 8'h85, 8'hab);
    $display("pointer test done");
  end
  endtask
  task automatic t_ports;
    logic [7:0] la [3] = '{8'h80, 8'h90, 8'ha0};
    logic [7:0] da [3] = '{8'ha2, 8'h91, 8'ha1};
    int p;
  begin
    for (p = 0; p < 3; p++)
    begin
      wr(da[p], 8'h0f);
      wr(la[p], 8'ha5);
      ext[p] = 8'h3c;
      repeat (3) tick;
      chk("latch", pout[p], 16'h00a5);
      chk("direction", poe[p], 16'h000f);
      rd_chk("pins", la[p], 8'h35);
    end
    wr(8'h87, 8'h55);
    rd_chk("unmapped", 8'h87, 8'h00);
    $display("port test done");
  end
  endtask
  task automatic t_moves;
    int s, w, k, na, nr, nw;
  begin
    for (s = 0; s < 8; s++)
      for (w = 0; w < 2; w++)
      begin
        wr(8'h8e, 8'(s));
        i_xmem_write = w[0];
        i_xmem_start = 1'b1;
        tick;
        i_xmem_start = 1'b0;
        chk("move addr", o_xmem_addr, 16'habcd);
        na = 0;
        nr = 0;
        nw = 0;
        for (k = 0; k < 14; k++)
        begin
          na += o_addr_valid;
          nr += o_read_strobe;
          nw += o_write_strobe;
          tick;
        end
        chk("addr valid", 16'(na), 16'(s + 1 + w));
        chk("read strobe", 16'(nr), w ? 16'h0 : 16'(s + 1));
        chk("write strobe", 16'(nw), w ? 16'((s == 0) ? 1 : s) : 16'h0);
        chk("busy", {15'h0, o_xmem_busy}, 16'h0);
      end
    wr(8'h8e, 8'h01);
    $display("move test done");
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge i_clock);
    #1 i_rst = 1'b0;
    t_reset;
    t_status;
    t_stack_pc;
    t_pointers;
    t_ports;
    t_moves;
    give_verdict;
  end
  // Hang guard
  initial
  begin
    #200000;
    fail_count = fail_count + 1;
    give_verdict;
  end
endmodule // tb_sfr_core_bank

// [xmem_strobe.v]
// Purpose: Times the external data memory strobes from the stretch value
// Assumes: Start is a one-cycle pulse while idle
// Notes: Address strobe opens with the data strobe
`timescale 1ns/10ps
`include "sfr_core_map.vh"

module xmem_strobe
(
  input wire i_clock,
  input wire i_rst,
  input wire i_start,
  input wire i_write,
  input wire [2:0] i_stretch,
  output wire o_busy,
  output reg o_addr_valid,
  output reg o_read_strobe,
  output reg o_write_strobe
);

  reg [3:0] addr_cnt_reg; // Address strobe cycles left
  reg [3:0] data_cnt_reg; // Data strobe cycles left
  reg write_reg; // Current move is a write
  wire [3:0] stretch_w; // Stretch widened
  wire [3:0] wr_width; // Write strobe width

  assign stretch_w = {1'b0, i_stretch};
  assign wr_width = (stretch_w == 4'h0) ? `WR_STROBE_MIN : stretch_w; // RL16
  assign o_busy = (addr_cnt_reg != 4'h0);

  // Strobe counters
  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      addr_cnt_reg <= 4'h0;
      data_cnt_reg <= 4'h0;
      write_reg <= 1'b0;
      o_addr_valid <= 1'b0;
      o_read_strobe <= 1'b0;
      o_write_strobe <= 1'b0;
    end
    else if (i_start && !o_busy)
    begin
      write_reg <= i_write;
      o_addr_valid <= 1'b1;
      if (i_write)
      begin
        addr_cnt_reg <= stretch_w + `WR_ADDR_EXTRA; // RL16
        data_cnt_reg <= wr_width;
        o_write_strobe <= 1'b1;
      end
      else
      begin
        addr_cnt_reg <= stretch_w + `RD_EXTRA; // RL15
        data_cnt_reg <= stretch_w + `RD_EXTRA; // RL15
        o_read_strobe <= 1'b1;
      end
    end
    else
    begin
      if (addr_cnt_reg != 4'h0)
        addr_cnt_reg <= addr_cnt_reg - 4'h1;
      if (data_cnt_reg != 4'h0)
        data_cnt_reg <= data_cnt_reg - 4'h1;
      o_addr_valid <= (addr_cnt_reg > 4'h1);
      o_read_strobe <= !write_reg && (data_cnt_reg > 4'h1);
      o_write_strobe <= write_reg && (data_cnt_reg > 4'h1);
    end
  end

endmodule // xmem_strobe
